// *** signon_codec.sv ***
// terminal-side sign-on codec: parses request bytes, emits response bytes
// assumes byte streams from/to a MAC framer on core_clk; one message at a time
//
// Behaviour
// - requests only arrive on the receive side; responses only leave on transmit side.
// - public-key byte bit 0 is 512-bit key agreement, size 64; rest zero.
// - hash byte bit 0 is keyed SHA-1, size 20; rest zero.
// - encryption bit 3 AES counter, bit 2 AES chaining; bits 7..4 zero.
// - bit 1 long DES, bit 0 short DES; sizes 24, 16 and 8.
// - version bit of the context word is sent as zero.
// - context word holds type flag, 24-bit stream id, 6-bit context index.
// - type zero means encapsulated stream; multicast id low 23 bits equal MAC.
// - own unicast encapsulated stream uses zero stream id and zero index.
// - type one means ATM circuit: 8-bit VPI above 16-bit VCI.
// - terminal supports key agreement, keyed SHA-1, short DES, 8-byte nonce.
// - negotiated selections are held while registered.
// - held sizes set later key-exchange field lengths.
// - response sets exactly one bit per field, or zero when unsupported.
// - any negotiation failure requests logoff.
// - resend after timeout; fail after more than three; discard late duplicates.
`timescale 1ns/1ps
`default_nettype none
`include "signon_regs.svh"

module signon_codec #(
  parameter int unsigned TMO_CYCLES  = `SIGNON_TMO_MS * 1000 * `CLK_MHZ,
  parameter int unsigned MAX_RETRIES = `MAX_RETRIES
) (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        srst,
  // control
  input  wire logic        registered,
  input  wire logic        des_long_en,
  // request byte stream from the control centre
  input  wire logic        rx_valid,
  input  wire logic [7:0]  rx_data,
  input  wire logic        rx_first,
  // response byte stream to the control centre
  output logic             tx_valid,
  output logic [7:0]       tx_data,
  output logic             tx_first,
  output logic             tx_last,
  input  wire logic        tx_ready,
  // acknowledge from the control centre for our response
  input  wire logic        resp_ack,
  // negotiated result
  output logic             sel_valid_r,
  output logic [7:0]       sel_pka_r,
  output logic [7:0]       sel_hash_r,
  output logic [7:0]       sel_enc_r,
  output logic [7:0]       sel_nonce_r,
  output logic [7:0]       size_pka_r,
  output logic [7:0]       size_hash_r,
  output logic [7:0]       size_enc_r,
  output logic [7:0]       size_nonce_r,
  output logic             stream_type_flag_r,
  output logic [23:0]      stream_identifier_r,
  output logic [5:0]       crypto_context_index_r,
  output logic [7:0]       vpi_r,
  output logic [15:0]      vci_r,
  output logic [22:0]      mcast_low_r,
  output logic             unicast_ok_r,
  // status
  output logic             logoff_req_r,
  output logic             dup_drop_r
);

  signon_pkg::codec_state_t state_r;
  signon_pkg::codec_state_t state_nxt;
  signon_pkg::choice_set_t  offer_r;
  logic [31:0]              ctx_r;
  logic [2:0]               rx_idx_r;
  logic [2:0]               tx_idx_r;
  logic [31:0]              tmo_r;
  logic [2:0]               retry_r;
  logic                     rx_done;
  logic                     tx_done;
  logic                     tmo_hit;
  logic                     dup_seen;
  logic [7:0]               tx_byte;

  choice_if ch ();

  choice_select u_sel (
    .ch (ch)
  );

  assign ch.offer       = offer_r;
  assign ch.des_long_en = des_long_en;

  function automatic logic [7:0] resp_byte(input logic [2:0] idx,
                                           input signon_pkg::choice_set_t p,
                                           input logic [31:0] c);
    logic [31:0] w;
    w = c;
    w[`CTX_VERSION] = 1'b0;
    case (idx)
      `IDX_PKA:   resp_byte = p.pka;
      `IDX_HASH:  resp_byte = p.hash;
      `IDX_ENC:   resp_byte = p.enc;
      `IDX_NONCE: resp_byte = p.nonce;
      3'h4:       resp_byte = w[31:24];
      3'h5:       resp_byte = w[23:16];
      3'h6:       resp_byte = w[15:8];
      default:    resp_byte = w[7:0];
    endcase
  endfunction : resp_byte

  assign rx_done  = rx_valid && (rx_idx_r == `IDX_LAST);
  assign tx_done  = tx_valid && tx_ready && tx_last;
  assign tmo_hit  = (tmo_r == TMO_CYCLES - 1);
  // a new request after we finished is a resent copy
  assign dup_seen = rx_valid && rx_first && (state_r == signon_pkg::ST_DONE);
  assign tx_byte  = resp_byte(tx_idx_r, ch.pick, ctx_r);

  // next state
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      signon_pkg::ST_IDLE: begin
        if (rx_valid && rx_first) begin
          state_nxt = signon_pkg::ST_RECV;
        end
      end
      signon_pkg::ST_RECV: begin
        if (rx_done) begin
          state_nxt = signon_pkg::ST_SEND;
        end
      end
      signon_pkg::ST_SEND: begin
        if (tx_done) begin
          state_nxt = signon_pkg::ST_WAIT;
        end
      end
      signon_pkg::ST_WAIT: begin
        if (resp_ack) begin
          state_nxt = ch.all_ok ? signon_pkg::ST_DONE : signon_pkg::ST_FAIL;
        end else if (tmo_hit) begin
          state_nxt = (retry_r == 3'(MAX_RETRIES)) ? signon_pkg::ST_FAIL
                                                   : signon_pkg::ST_SEND;
        end
      end
      signon_pkg::ST_DONE: begin
        if (!registered) begin
          state_nxt = signon_pkg::ST_IDLE;
        end
      end
      signon_pkg::ST_FAIL: begin
        if (!registered) begin
          state_nxt = signon_pkg::ST_IDLE;
        end
      end
      default: state_nxt = signon_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      state_r <= signon_pkg::ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // request capture
  always_ff @(posedge core_clk) begin
    if (srst) begin
      rx_idx_r <= 3'h0;
      offer_r  <= '0;
      ctx_r    <= 32'h0000_0000;
    end else if (rx_valid && ((state_r == signon_pkg::ST_IDLE && rx_first)
                              || state_r == signon_pkg::ST_RECV)) begin
      rx_idx_r <= (rx_idx_r == `IDX_LAST) ? 3'h0 : rx_idx_r + 3'h1;
      case (rx_idx_r)
        `IDX_PKA:   offer_r.pka   <= rx_data;
        `IDX_HASH:  offer_r.hash  <= rx_data;
        `IDX_ENC:   offer_r.enc   <= rx_data;
        `IDX_NONCE: offer_r.nonce <= rx_data;
        default:    ctx_r         <= {ctx_r[23:0], rx_data};
      endcase
    end
  end

  // response emission, resent unchanged on timeout
  always_ff @(posedge core_clk) begin
    if (srst) begin
      tx_valid <= 1'b0;
      tx_data  <= 8'h00;
      tx_first <= 1'b0;
      tx_last  <= 1'b0;
      tx_idx_r <= 3'h0;
    end else if (state_r == signon_pkg::ST_SEND) begin
      if (!tx_valid || tx_ready) begin
        if (tx_valid && tx_last) begin
          tx_valid <= 1'b0;
          tx_first <= 1'b0;
          tx_last  <= 1'b0;
          tx_idx_r <= 3'h0;
        end else begin
          tx_valid <= 1'b1;
          tx_data  <= tx_byte;
          tx_first <= (tx_idx_r == `IDX_PKA);
          tx_last  <= (tx_idx_r == `IDX_LAST);
          tx_idx_r <= tx_idx_r + 3'h1;
        end
      end
    end else begin
      tx_valid <= 1'b0;
      tx_first <= 1'b0;
      tx_last  <= 1'b0;
      tx_idx_r <= 3'h0;
    end
  end

  // timeout and retry counting
  always_ff @(posedge core_clk) begin
    if (srst) begin
      tmo_r   <= 32'h0000_0000;
      retry_r <= 3'h0;
    end else if (state_r == signon_pkg::ST_WAIT) begin
      tmo_r <= tmo_hit ? 32'h0000_0000 : tmo_r + 32'h0000_0001;
      if (tmo_hit) begin
        retry_r <= retry_r + 3'h1;
      end
    end else begin
      tmo_r <= 32'h0000_0000;
      if (state_r == signon_pkg::ST_IDLE) begin
        retry_r <= 3'h0;
      end
    end
  end

  // negotiated selections kept while registered
  always_ff @(posedge core_clk) begin
    if (srst || !registered) begin
      sel_valid_r  <= 1'b0;
      sel_pka_r    <= 8'h00;
      sel_hash_r   <= 8'h00;
      sel_enc_r    <= 8'h00;
      sel_nonce_r  <= 8'h00;
      size_pka_r   <= `SIZE_NONE;
      size_hash_r  <= `SIZE_NONE;
      size_enc_r   <= `SIZE_NONE;
      size_nonce_r <= `SIZE_NONE;
    end else if (state_r == signon_pkg::ST_WAIT && resp_ack && ch.all_ok) begin
      sel_valid_r  <= 1'b1;
      sel_pka_r    <= ch.pick.pka;
      sel_hash_r   <= ch.pick.hash;
      sel_enc_r    <= ch.pick.enc;
      sel_nonce_r  <= ch.pick.nonce;
      size_pka_r   <= ch.size_pka;
      size_hash_r  <= ch.size_hash;
      size_enc_r   <= ch.size_enc;
      size_nonce_r <= ch.size_nonce;
    end
  end

  // stream decode of the context word
  always_ff @(posedge core_clk) begin
    if (srst) begin
      stream_type_flag_r     <= 1'b0;
      stream_identifier_r    <= 24'h00_0000;
      crypto_context_index_r <= 6'h00;
      vpi_r                  <= 8'h00;
      vci_r                  <= 16'h0000;
      mcast_low_r            <= 23'h00_0000;
      unicast_ok_r           <= 1'b0;
    end else if (state_r == signon_pkg::ST_SEND) begin
      stream_type_flag_r     <= ctx_r[`CTX_TYPE];
      stream_identifier_r    <= ctx_r[`CTX_ID_HI:`CTX_ID_LO];
      crypto_context_index_r <= ctx_r[`CTX_KEY_HI:`CTX_KEY_LO];
      vpi_r <= ctx_r[`CTX_ID_LO + `VPI_HI:`CTX_ID_LO + `VPI_LO];
      vci_r <= ctx_r[`CTX_ID_LO + `VCI_HI:`CTX_ID_LO + `VCI_LO];
      mcast_low_r <= ctx_r[`CTX_ID_LO + `MCAST_BITS - 1:`CTX_ID_LO];
      unicast_ok_r <= !ctx_r[`CTX_TYPE]
                      && (ctx_r[`CTX_ID_HI:`CTX_ID_LO] == 24'h00_0000)
                      && (ctx_r[`CTX_KEY_HI:`CTX_KEY_LO] == 6'h00);
    end
  end

  // logoff request and duplicate discard
  always_ff @(posedge core_clk) begin
    if (srst) begin
      logoff_req_r <= 1'b0;
      dup_drop_r   <= 1'b0;
    end else begin
      logoff_req_r <= (state_nxt == signon_pkg::ST_FAIL);
      dup_drop_r   <= dup_seen;
    end
  end

endmodule : signon_codec

`default_nettype wire

// *** signon_regs.svh ***
// offsets, field positions, sizes and timing counts for the sign-on codec
// included by signon_codec and choice_select; definitions only
`ifndef SIGNON_REGS_SVH
`define SIGNON_REGS_SVH

// message layout, byte order on the wire
`define MSG_BYTES        8
`define IDX_PKA          3'h0
`define IDX_HASH         3'h1
`define IDX_ENC          3'h2
`define IDX_NONCE        3'h3
`define IDX_CTX0         3'h4
`define IDX_LAST         3'h7

// choice byte bit positions
`define BIT_KEYAGREE     0
`define BIT_KEYED_SHA1   0
`define BIT_AES_CTR      3
`define BIT_AES_CHAIN    2
`define BIT_DES_LONG     1
`define BIT_DES_SHORT    0
`define BIT_NONCE8       0

// context word bit positions
`define CTX_VERSION      31
`define CTX_TYPE         30
`define CTX_ID_HI        29
`define CTX_ID_LO        6
`define CTX_KEY_HI       5
`define CTX_KEY_LO       0
`define MCAST_BITS       23
`define VPI_HI           23
`define VPI_LO           16
`define VCI_HI           15
`define VCI_LO           0

// parameter sizes in bytes
`define SIZE_KEYAGREE    8'h40
`define SIZE_SHA1        8'h14
`define SIZE_AES_CTR     8'h18
`define SIZE_AES_CHAIN   8'h10
`define SIZE_DES         8'h08
`define SIZE_NONCE8      8'h08
`define SIZE_NONE        8'h00

// retry handling
`define MAX_RETRIES      3
`define SIGNON_TMO_MS    700
`define CLK_MHZ          200

`endif

// *** signon_pkg.sv ***
// types shared by the sign-on codec modules
// constants themselves live in signon_regs.svh
package signon_pkg;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_RECV  = 3'b001,
    ST_SEND  = 3'b010,
    ST_WAIT  = 3'b011,
    ST_DONE  = 3'b100,
    ST_FAIL  = 3'b101
  } codec_state_t;

  typedef struct packed {
    logic [7:0] pka;
    logic [7:0] hash;
    logic [7:0] enc;
    logic [7:0] nonce;
  } choice_set_t;

endpackage : signon_pkg

// *** choice_if.sv ***
// carries offered choices to the selector and its answer back
// both ends on core_clk; purely combinational path
`timescale 1ns/1ps
`default_nettype none

interface choice_if;
  signon_pkg::choice_set_t offer;
  logic                    des_long_en;
  signon_pkg::choice_set_t pick;
  logic [7:0]              size_pka;
  logic [7:0]              size_hash;
  logic [7:0]              size_enc;
  logic [7:0]              size_nonce;
  logic                    all_ok;

  modport chooser (
    input  offer,
    input  des_long_en,
    output pick,
    output size_pka,
    output size_hash,
    output size_enc,
    output size_nonce,
    output all_ok
  );
  modport user (
    output offer,
    output des_long_en,
    input  pick,
    input  size_pka,
    input  size_hash,
    input  size_enc,
    input  size_nonce,
    input  all_ok
  );
endinterface : choice_if

`default_nettype wire

// *** choice_select.sv ***
// picks one supported choice per class and gives parameter sizes
// pure combinational; offer bytes already captured by the caller
`timescale 1ns/1ps
`default_nettype none
`include "signon_regs.svh"

module choice_select (
  choice_if.chooser ch
);

  // reserved bits of the offer are masked, never checked
  always_comb begin
    ch.pick       = '0;
    ch.size_pka   = `SIZE_NONE;
    ch.size_hash  = `SIZE_NONE;
    ch.size_enc   = `SIZE_NONE;
    ch.size_nonce = `SIZE_NONE;
    if (ch.offer.pka[`BIT_KEYAGREE]) begin
      ch.pick.pka[`BIT_KEYAGREE] = 1'b1;
      ch.size_pka                = `SIZE_KEYAGREE;
    end
    if (ch.offer.hash[`BIT_KEYED_SHA1]) begin
      ch.pick.hash[`BIT_KEYED_SHA1] = 1'b1;
      ch.size_hash                  = `SIZE_SHA1;
    end
    // strongest supported cipher first
    if (ch.offer.enc[`BIT_AES_CTR]) begin
      ch.pick.enc[`BIT_AES_CTR] = 1'b1;
      ch.size_enc               = `SIZE_AES_CTR;
    end else if (ch.offer.enc[`BIT_AES_CHAIN]) begin
      ch.pick.enc[`BIT_AES_CHAIN] = 1'b1;
      ch.size_enc                 = `SIZE_AES_CHAIN;
    end else if (ch.offer.enc[`BIT_DES_LONG] && ch.des_long_en) begin
      ch.pick.enc[`BIT_DES_LONG] = 1'b1;
      ch.size_enc                = `SIZE_DES;
    end else if (ch.offer.enc[`BIT_DES_SHORT]) begin
      ch.pick.enc[`BIT_DES_SHORT] = 1'b1;
      ch.size_enc                 = `SIZE_DES;
    end
    if (ch.offer.nonce[`BIT_NONCE8]) begin
      ch.pick.nonce[`BIT_NONCE8] = 1'b1;
      ch.size_nonce              = `SIZE_NONCE8;
    end
  end

  assign ch.all_ok = (ch.size_pka != `SIZE_NONE) && (ch.size_hash != `SIZE_NONE)
                     && (ch.size_enc != `SIZE_NONE) && (ch.size_nonce != `SIZE_NONE);

endmodule : choice_select

`default_nettype wire

// *** signon_codec_properties.sv ***
// concurrent checks on the sign-on codec top ports
// bound into every signon_codec instance; single core_clk domain
`timescale 1ns/1ps
`default_nettype none

module signon_checker (
  // clock and reset
  input wire logic        core_clk,
  input wire logic        srst,
  // control
  input wire logic        registered,
  // response stream
  input wire logic        tx_valid,
  input wire logic [7:0]  tx_data,
  input wire logic        tx_first,
  input wire logic        tx_last,
  input wire logic        tx_ready,
  // negotiated result
  input wire logic        sel_valid_r,
  input wire logic [7:0]  sel_pka_r,
  input wire logic [7:0]  sel_hash_r,
  input wire logic [7:0]  sel_enc_r,
  input wire logic [7:0]  sel_nonce_r,
  input wire logic [7:0]  size_pka_r,
  input wire logic [7:0]  size_hash_r,
  input wire logic [7:0]  size_enc_r,
  input wire logic [7:0]  size_nonce_r,
  // stream decode
  input wire logic        stream_type_flag_r,
  input wire logic [23:0] stream_identifier_r,
  input wire logic [7:0]  vpi_r,
  input wire logic [15:0] vci_r,
  // status
  input wire logic        logoff_req_r
);
  logic [2:0] idx_r;

  // position of the byte on offer within the response
  always_ff @(posedge core_clk) begin
    if (srst)
      idx_r <= 3'h0;
    else if (tx_valid && tx_ready)
      idx_r <= tx_last ? 3'h0 : idx_r + 3'h1;
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (srst);

  sequence s_stalled;
    tx_valid && !tx_ready;
  endsequence
  sequence s_last_taken;
    tx_valid && tx_ready && tx_last;
  endsequence

  property p_onehot;
    sel_valid_r |-> $onehot(sel_pka_r) && $onehot(sel_hash_r) && $onehot(sel_enc_r)
      && $onehot(sel_nonce_r);
  endproperty
  a_onehot: assert property (p_onehot) else $error("selection not one-hot");
  property p_sizes;
    sel_valid_r |-> size_pka_r == 8'h40 && size_hash_r == 8'h14 && size_nonce_r == 8'h08;
  endproperty
  a_sizes: assert property (p_sizes) else $error("fixed size wrong");
  property p_enc_size;
    sel_valid_r |-> size_enc_r == (sel_enc_r[3] ? 8'h18 : (sel_enc_r[2] ? 8'h10 : 8'h08));
  endproperty
  a_enc_size: assert property (p_enc_size) else $error("cipher size wrong");
  property p_hold;
    sel_valid_r && registered |=> $stable({sel_pka_r, sel_hash_r, sel_enc_r, sel_nonce_r});
  endproperty
  a_hold: assert property (p_hold) else $error("selection changed");
  property p_stand;
    s_stalled |=> tx_valid && $stable(tx_data);
  endproperty
  a_stand: assert property (p_stand) else $error("byte dropped in stall");
  property p_gap;
    s_last_taken |=> !tx_valid;
  endproperty
  a_gap: assert property (p_gap) else $error("no gap after frame");
  property p_version;
    tx_valid && idx_r == 3'h4 |-> !tx_data[7];
  endproperty
  a_version: assert property (p_version) else $error("version bit set");
  property p_choice;
    tx_valid && idx_r < 3'h4 |-> $onehot0(tx_data);
  endproperty
  a_choice: assert property (p_choice) else $error("choice byte multi-bit");
  property p_frame;
    tx_valid |-> tx_first == (idx_r == 3'h0) && tx_last == (idx_r == 3'h7);
  endproperty
  a_frame: assert property (p_frame) else $error("frame markers wrong");
  property p_logoff;
    logoff_req_r && registered |=> logoff_req_r;
  endproperty
  a_logoff: assert property (p_logoff) else $error("logoff dropped");
  property p_vpi;
    stream_type_flag_r |-> {vpi_r, vci_r} == stream_identifier_r;
  endproperty
  a_vpi: assert property (p_vpi) else $error("circuit split wrong");
endmodule : signon_checker

bind signon_codec signon_checker signon_checker_i (
  .core_clk(core_clk), .srst(srst), .registered(registered), .tx_valid(tx_valid),
  .tx_data(tx_data), .tx_first(tx_first), .tx_last(tx_last), .tx_ready(tx_ready),
  .sel_valid_r(sel_valid_r), .sel_pka_r(sel_pka_r), .sel_hash_r(sel_hash_r),
  .sel_enc_r(sel_enc_r), .sel_nonce_r(sel_nonce_r), .size_pka_r(size_pka_r),
  .size_hash_r(size_hash_r), .size_enc_r(size_enc_r), .size_nonce_r(size_nonce_r),
  .stream_type_flag_r(stream_type_flag_r), .stream_identifier_r(stream_identifier_r),
  .vpi_r(vpi_r), .vci_r(vci_r), .logoff_req_r(logoff_req_r));

`default_nettype wire

// *** ncc_model.sv ***
// control-centre model: sends requests, takes responses, acknowledges
// driven by testbench tasks; shares core_clk with the codec
`timescale 1ns/1ps
`default_nettype none

module ncc_model (
  // clock
  input  wire logic       core_clk,
  // request stream to the terminal
  output logic            rx_valid,
  output logic [7:0]      rx_data,
  output logic            rx_first,
  // response stream from the terminal
  input  wire logic       tx_valid,
  input  wire logic       tx_last,
  input  wire logic       stall,
  output logic            tx_ready,
  output logic            resp_ack
);
  assign tx_ready = !stall;

  initial begin
    {rx_valid, rx_first, rx_data} = 10'h000;
    resp_ack = 1'b0;
  end

  // requests only toward the terminal, offer bytes first
  task automatic send_req(input logic [63:0] m);
    for (int i = 7; i >= 0; i--) begin
      @(posedge core_clk);
      #1 {rx_valid, rx_first, rx_data} = {1'b1, i == 7, m[i*8 +: 8]};
    end
    @(posedge core_clk);
    // released line shows the inverse of the last byte
    #1 {rx_valid, rx_first, rx_data} = {2'b00, ~rx_data};
  endtask : send_req

  task automatic ack_resp();
    int n;
    for (n = 0; n < 300; n++) begin
      @(posedge core_clk);
      #2;
      if (tx_valid && tx_ready && tx_last)
        break;
    end
    @(posedge core_clk);
    #1 resp_ack = 1'b1;
    @(posedge core_clk);
    #1 resp_ack = 1'b0;
  endtask : ack_resp
endmodule : ncc_model

`default_nettype wire

// *** testbench.sv ***
// self-checking bench for the sign-on codec
// codec, control-centre model and bound checker on one core_clk
`timescale 1ns/1ps
`default_nettype none

module testbench;
  localparam int unsigned TMO = 20;
  localparam int unsigned RETRIES = 3;
  // offers and picks per row; des-long enable, ack, circuit type
  localparam logic [31:0] OFF [7] = '{32'hFFFFFFFF, 32'h0101F601, 32'h01010301,
    32'h01010301, 32'h01000101, 32'h01010101, 32'h01010201};
  localparam logic [31:0] PICK [7] = '{32'h01010801, 32'h01010401, 32'h01010201,
    32'h01010101, 32'h01000101, 32'h01010101, 32'h01010001};
  localparam logic [6:0] DL = 7'h04;
  localparam logic [6:0] ACK = 7'h5F;
  localparam logic [6:0] TYP = 7'h2A;
  logic        core_clk = 1'b0;
  logic        srst = 1'b1;
  logic        registered = 1'b0;
  logic        des_long_en = 1'b0;
  logic        stall = 1'b0;
  logic        rx_valid, rx_first, tx_valid, tx_first, tx_last, tx_ready, resp_ack;
  logic [7:0]  rx_data, tx_data, vpi_r;
  logic        sel_valid_r, stream_type_flag_r, unicast_ok_r, logoff_req_r, dup_drop_r;
  logic [7:0]  sel_pka_r, sel_hash_r, sel_enc_r, sel_nonce_r;
  logic [7:0]  size_pka_r, size_hash_r, size_enc_r, size_nonce_r;
  logic [23:0] stream_identifier_r;
  logic [5:0]  crypto_context_index_r;
  logic [15:0] vci_r;
  logic [22:0] mcast_low_r;
  logic [31:0] seed = 32'h0000E1CD;
  logic [7:0]  exp_tx [$];
  logic [63:0] exp_sel [$];
  int          n_mismatch = 0;
  int          checks = 0;
  int          dup_cnt = 0;
  wire logic [63:0] sel_all = {sel_pka_r, sel_hash_r, sel_enc_r, sel_nonce_r,
    size_pka_r, size_hash_r, size_enc_r, size_nonce_r};
  wire logic [30:0] ctx_out = {stream_type_flag_r, stream_identifier_r, crypto_context_index_r};
  wire logic [23:0] id_out = stream_type_flag_r ? {vpi_r, vci_r} : {1'b0, mcast_low_r};

  signon_codec #(.TMO_CYCLES(TMO), .MAX_RETRIES(RETRIES)) signon_codec_i (
    .core_clk(core_clk), .srst(srst), .registered(registered), .des_long_en(des_long_en),
    .rx_valid(rx_valid), .rx_data(rx_data), .rx_first(rx_first), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_first(tx_first), .tx_last(tx_last), .tx_ready(tx_ready),
    .resp_ack(resp_ack), .sel_valid_r(sel_valid_r), .sel_pka_r(sel_pka_r),
    .sel_hash_r(sel_hash_r), .sel_enc_r(sel_enc_r), .sel_nonce_r(sel_nonce_r),
    .size_pka_r(size_pka_r), .size_hash_r(size_hash_r), .size_enc_r(size_enc_r),
    .size_nonce_r(size_nonce_r), .stream_type_flag_r(stream_type_flag_r),
    .stream_identifier_r(stream_identifier_r),
    .crypto_context_index_r(crypto_context_index_r),
    .vpi_r(vpi_r), .vci_r(vci_r), .mcast_low_r(mcast_low_r), .unicast_ok_r(unicast_ok_r),
    .logoff_req_r(logoff_req_r), .dup_drop_r(dup_drop_r));
  ncc_model ncc_model_i (.core_clk(core_clk), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_first(rx_first), .tx_valid(tx_valid), .tx_last(tx_last), .stall(stall),
    .tx_ready(tx_ready), .resp_ack(resp_ack));

  always #2.5 core_clk = ~core_clk;

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  function automatic logic [31:0] sz(input logic [31:0] p);
    return {8'h40, 8'h14, p[11] ? 8'h18 : (p[10] ? 8'h10 : 8'h08), 8'h08};
  endfunction : sz

  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic end_sim();
    $display("mismatches %0d checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : end_sim

  task automatic nego(input int i);
    logic [31:0] r;
    logic [31:0] ctx;
    logic [63:0] m;
    logic        bad;
    int          n;
    r = rnd();
    ctx = (i == 0) ? 32'h00000000 : {1'b0, TYP[i], r[29:0]};
    m = {PICK[i], ctx & 32'h7FFFFFFF};
    bad = !ACK[i] || PICK[i][31:24] == 8'h00 || PICK[i][23:16] == 8'h00
      || PICK[i][15:8] == 8'h00 || PICK[i][7:0] == 8'h00;
    registered = 1'b0;
    repeat (2) @(posedge core_clk);
    #1 chk(sel_valid_r, 1'b0, "selection cleared");
    registered = 1'b1;
    des_long_en = DL[i];
    for (n = 0; n <= (ACK[i] ? 0 : RETRIES); n++) begin
      for (int b = 7; b >= 0; b--)
        exp_tx.push_back(m[b*8 +: 8]);
    end
    if (!bad)
      exp_sel.push_back({PICK[i], sz(PICK[i])});
    ncc_model_i.send_req({OFF[i], ctx});
    if (ACK[i])
      ncc_model_i.ack_resp();
    for (n = 0; n < 400 && (ACK[i] ? n < 2 : logoff_req_r !== 1'b1); n++)
      @(posedge core_clk);
    #1 chk(logoff_req_r, bad, "logoff");
    chk(exp_tx.size(), 0, "response copies");
    chk(ctx_out, ctx[30:0], "context word");
    chk(unicast_ok_r, ctx[30:0] == 31'h0, "own unicast");
    chk(id_out, ctx[30] ? ctx[29:6] : {1'b0, ctx[28:6]}, "stream id");
  endtask : nego

  always @(posedge core_clk) begin
    if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
      if (exp_tx.size() == 0)
        chk(1, 0, "unexpected byte");
      else
        chk(tx_data, exp_tx.pop_front(), "response byte");
    end
    if (dup_drop_r === 1'b1)
      dup_cnt++;
  end

  always @(posedge sel_valid_r) begin
    #1 chk(sel_all, exp_sel.pop_front(), "selection");
  end

  always @(posedge core_clk) begin
    #1 stall = (rnd() & 32'h00000003) == 32'h00000000;
  end

  initial begin
    repeat (8) @(posedge core_clk);
    #1 srst = 1'b0;
    for (int i = 0; i < 7; i++) begin
      nego(i);
      if (i == 0) begin
        ncc_model_i.send_req({OFF[0], 32'h00000000});
        repeat (4) @(posedge core_clk);
        #1 chk(dup_cnt, 1, "duplicate dropped");
        chk(sel_valid_r, 1'b1, "selection kept");
      end
    end
    end_sim();
  end

  initial begin
    #100000;
    n_mismatch++;
    $display("CHECK FAILED %0t watchdog expired", $time);
    end_sim();
  end
endmodule : testbench

`default_nettype wire
